// >>> src/dpll_reference_selector.sv
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
module dpll_reference_selector
   import dpll_sel_pkg::*;
(
   // clock and reset
   input  wire logic                          clk,
   input  wire logic                          nrst,
   // monitors and pins
   input  wire logic [dpll_sel_pkg::NPOS-1:0] clkValid,
   input  wire logic                          fastMiss,
   input  wire logic                          sourceSwitchPin,
   // selection results
   output logic [dpll_sel_pkg::CODE_W-1:0]    mainSelCode,
   output logic [dpll_sel_pkg::CODE_W-1:0]    auxSelCode,
   output logic                               bucketFillMax,
   output logic                               enterPrelocked2,
   output logic                               selFailOut,
   output logic                               freqLimitWide,
   // axi4-lite write
   input  wire logic [dpll_sel_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                          awvalid,
   output logic                               awready,
   input  wire logic [31:0]                   wdata,
   input  wire logic [3:0]                    wstrb,
   input  wire logic                          wvalid,
   output logic                               wready,
   output logic [1:0]                         bresp,
   output logic                               bvalid,
   input  wire logic                          bready,
   // axi4-lite read
   input  wire logic [dpll_sel_pkg::ADDR_W-1:0] araddr,
   input  wire logic                          arvalid,
   output logic                               arready,
   output logic [31:0]                        rdata,
   output logic [1:0]                         rresp,
   output logic                               rvalid,
   input  wire logic                          rready
);
   import dpll_sel_pkg::*;

   function automatic logic [3:0] pickBest(input logic [NPOS-1:0] cand,
                                           input logic [NPOS*KEY_W-1:0] keys);
      logic             found;
      logic [KEY_W-1:0] bestKey;
      logic [2:0]       bestPos;
      found   = 1'b0;
      bestKey = '0;
      bestPos = 3'h0;
      for (int i = 0; i < NPOS; i++) begin
         if (cand[i] && (!found || keys[i*KEY_W +: KEY_W] < bestKey)) begin
            found   = 1'b1;
            bestKey = keys[i*KEY_W +: KEY_W];
            bestPos = 3'(i);
         end
      end
      pickBest = {found, bestPos};
   endfunction : pickBest

   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
      for (int b = 0; b < 4; b++) begin
         old[b*8 +: 8] = strb[b] ? data[b*8 +: 8] : old[b*8 +: 8];
      end
      mergeBytes = old;
   endfunction : mergeBytes

   logic [31:0]    prioMain_ff;
   logic [31:0]    prioAux_ff;
   logic [31:0]    ctrl_ff;
   logic [2:0]     status_ff;
   logic           freqWide_ff;
   logic [1:0]     strapCnt_ff;
   logic           pinMeta_ff;
   logic           pinSync_ff;
   logic           bucketFillMax_ff;
   logic           enterPrelocked2_ff;
   logic           awHeld_ff;
   logic           wHeld_ff;
   logic [ADDR_W-1:0] wrAddr_ff;
   logic [31:0]    wrData_ff;
   logic [3:0]     wrStrb_ff;
   logic           bvalid_ff;
   logic [1:0]     bresp_ff;
   logic           rvalid_ff;
   logic [31:0]    rdata_ff;
   logic [1:0]     rresp_ff;

   logic           revertEn;
   logic           ufsEn;
   logic           extSwEn;
   logic           phaseMode;
   logic           ufsTrig;
   logic           failSet;
   logic           wrFire;
   logic           wrMapped;
   logic [3:0]     selCode   [2];
   logic [3:0]     topCode   [2];
   logic [3:0]     secCode   [2];
   logic [3:0]     thirdCode [2];
   logic [3:0]     topNxt    [2];
   logic           selInSet  [2];
   logic           betterW   [2];
   logic           betterRise[2];
   logic [3:0]     extCode;
   logic [3:0]     mainSelInfo;

   assign revertEn  = ctrl_ff[CB_REVERTIVE_ENABLE];
   assign ufsEn     = ctrl_ff[CB_UFS];
   assign extSwEn   = ctrl_ff[CB_EXTERNAL_SWITCH_ENABLE];
   assign phaseMode = ctrl_ff[CB_PHASE];
   // fast monitor only matters while something is selected
   assign mainSelInfo = codeToPos(selCode[0]);
   assign failSet   = fastMiss && mainSelInfo[3];
   assign ufsTrig   = ufsEn && failSet;

   // pin high: three unless disabled, else five; low: four or six
   assign extCode = pinSync_ff ?
      ((prioMain_ff[POS_THREE*4 +: 4] != 4'h0) ? INPUT_THREE : INPUT_FIVE) :
      ((prioMain_ff[POS_FOUR*4 +: 4] != 4'h0) ? INPUT_FOUR : INPUT_SIX);

   for (genvar g = 0; g < 2; g++) begin : loopGen
      logic [3:0]             sel_ff;
      logic [3:0]             top_ff;
      logic [3:0]             sec_ff;
      logic [3:0]             third_ff;
      logic                   betterPrev_ff;
      logic [3:0]             nxt_sel;
      logic [3:0]             topInfo;
      logic [3:0]             secInfo;
      logic [3:0]             thirdInfo;
      logic [NPOS-1:0]        cand;
      logic [NPOS*KEY_W-1:0]  keys;
      logic                   selIn;
      logic                   better;

      always_comb begin
         logic [31:0] prio;
         logic [3:0]  forceCode;
         logic [3:0]  forceInfo;
         logic [3:0]  selInfo;
         logic        forceAuto;
         logic        forced;
         logic [3:0]  pr;
         logic        rev;
         forced    = 1'b0;
         pr        = 4'h0;
         prio      = (g == 0) ? prioMain_ff : prioAux_ff;
         forceCode = (g == 0) ? ctrl_ff[CF_MFORCE_LSB +: 4] : ctrl_ff[CF_AFORCE_LSB +: 4];
         forceAuto = (forceCode == FORCE_AUTO_LO) || (forceCode == FORCE_AUTO_HI);
         forceInfo = codeToPos(forceCode);
         selInfo   = codeToPos(sel_ff);
         rev       = (g == 1) ? 1'b1 : revertEn;
         for (int i = 0; i < NPOS; i++) begin
            pr     = prio[i*4 +: 4];
            forced = !forceAuto && forceInfo[3] && (forceInfo[2:0] == 3'(i));
            // zero priority removes the input unless forced
            cand[i] = clkValid[i] && (pr != 4'h0 || forced) &&
                      !(g == 0 && ufsTrig && selInfo[3] && selInfo[2:0] == 3'(i));
            // forced input ranks above every real priority
            keys[i*KEY_W +: KEY_W] = {(forced ? 4'h0 : pr),
                                      3'(3'(i) - selInfo[2:0])};
         end
         topInfo   = pickBest(cand, keys);
         secInfo   = pickBest(cand & ~(NPOS'(topInfo[3]) << topInfo[2:0]), keys);
         thirdInfo = pickBest(cand & ~(NPOS'(topInfo[3]) << topInfo[2:0])
                                   & ~(NPOS'(secInfo[3]) << secInfo[2:0]), keys);
         selIn     = selInfo[3] && cand[selInfo[2:0]];
         // strict compare: a tie on priority never reverts
         better    = topInfo[3] && selIn &&
                     (keys[topInfo[2:0]*KEY_W + 3 +: 4] < keys[selInfo[2:0]*KEY_W + 3 +: 4]);
         if (g == 0 && extSwEn) begin
            nxt_sel = extCode;
         end else if (g == 1 && phaseMode && !forceAuto) begin
            nxt_sel = forceInfo[3] ? forceCode : 4'h0;
         end else if (!forceAuto && !forceInfo[3]) begin
            nxt_sel = 4'h0;
         end else if (!selIn) begin
            nxt_sel = topInfo[3] ? posToCode(topInfo[2:0]) : 4'h0;
         end else if (rev && better) begin
            nxt_sel = posToCode(topInfo[2:0]);
         end else begin
            nxt_sel = sel_ff;
         end
      end

      // top, second and third are rebuilt each cycle from validity and priorities; the selection is loaded from nxt_sel
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            sel_ff        <= 4'h0;
            top_ff        <= 4'h0;
            sec_ff        <= 4'h0;
            third_ff      <= 4'h0;
            betterPrev_ff <= 1'b0;
         end else begin
            sel_ff        <= nxt_sel;
            top_ff        <= topInfo[3] ? posToCode(topInfo[2:0]) : 4'h0;
            sec_ff        <= secInfo[3] ? posToCode(secInfo[2:0]) : 4'h0;
            third_ff      <= thirdInfo[3] ? posToCode(thirdInfo[2:0]) : 4'h0;
            betterPrev_ff <= better;
         end
      end

      assign selCode[g]    = sel_ff;
      assign topCode[g]    = top_ff;
      assign secCode[g]    = sec_ff;
      assign thirdCode[g]  = third_ff;
      assign topNxt[g]     = topInfo[3] ? posToCode(topInfo[2:0]) : 4'h0;
      assign selInSet[g]   = selIn;
      assign betterW[g]    = better;
      assign betterRise[g] = better && !betterPrev_ff;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pinMeta_ff <= 1'b0;
         pinSync_ff <= 1'b0;
      end else begin
         pinMeta_ff <= sourceSwitchPin;
         pinSync_ff <= pinMeta_ff;
      end
   end

   // ultra-fast event: pulses toward bucket and loop state machine
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bucketFillMax_ff   <= 1'b0;
         enterPrelocked2_ff <= 1'b0;
      end else begin
         bucketFillMax_ff   <= ufsTrig;
         enterPrelocked2_ff <= ufsTrig;
      end
   end

   // strap caught once the pin synchroniser has filled
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         strapCnt_ff <= 2'h0;
         freqWide_ff <= 1'b0;
      end else if (strapCnt_ff != 2'h3) begin
         strapCnt_ff <= strapCnt_ff + 2'h1;
         if (strapCnt_ff == STRAP_WAIT) begin
            freqWide_ff <= pinSync_ff;
         end
      end
   end

   // axi4-lite write: address and data taken in either order
   assign wrFire   = awHeld_ff && wHeld_ff && !bvalid_ff;
   assign wrMapped = (wrAddr_ff == OFF_PRIO_MAIN) || (wrAddr_ff == OFF_PRIO_AUX) ||
                     (wrAddr_ff == OFF_CTRL) || (wrAddr_ff == OFF_STATUS);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         awHeld_ff <= 1'b0;
         wHeld_ff  <= 1'b0;
         wrAddr_ff <= '0;
         wrData_ff <= 32'h0;
         wrStrb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
      end else begin
         if (awvalid && !awHeld_ff) begin
            awHeld_ff <= 1'b1;
            wrAddr_ff <= {awaddr[ADDR_W-1:2], 2'h0};
         end
         if (wvalid && !wHeld_ff) begin
            wHeld_ff  <= 1'b1;
            wrData_ff <= wdata;
            wrStrb_ff <= wstrb;
         end
         if (wrFire) begin
            awHeld_ff <= 1'b0;
            wHeld_ff  <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_ff && bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prioMain_ff <= PRIO_MAIN_RST;
         prioAux_ff  <= PRIO_AUX_RST;
         ctrl_ff     <= CTRL_RST;
      end else begin
         if (wrFire && wrAddr_ff == OFF_PRIO_MAIN) begin
            prioMain_ff <= mergeBytes(prioMain_ff, wrData_ff, wrStrb_ff);
         end
         if (wrFire && wrAddr_ff == OFF_PRIO_AUX) begin
            prioAux_ff <= mergeBytes(prioAux_ff, wrData_ff, wrStrb_ff);
         end
         if (strapCnt_ff == STRAP_WAIT) begin
            ctrl_ff[CB_EXTERNAL_SWITCH_ENABLE] <= pinSync_ff;
         end else if (wrFire && wrAddr_ff == OFF_CTRL) begin
            ctrl_ff <= mergeBytes(ctrl_ff, wrData_ff, wrStrb_ff) & 32'h0000_FF1F;
         end
      end
   end

   // write-one-to-clear; a same-cycle event wins over the clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         status_ff <= 3'h0;
      end else begin
         status_ff <= (status_ff & ~((wrFire && wrAddr_ff == OFF_STATUS && wrStrb_ff[0]) ?
                                     wrData_ff[2:0] : 3'h0))
                      | {betterRise[1], betterRise[0], failSet};
      end
   end

   // axi4-lite read: one beat, answered the edge after the address
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0;
         rresp_ff  <= RESP_OKAY;
      end else if (arvalid && !rvalid_ff) begin
         rvalid_ff <= 1'b1;
         rresp_ff  <= RESP_OKAY;
         rdata_ff  <= 32'h0;
         if ({araddr[ADDR_W-1:2], 2'h0} == OFF_PRIO_MAIN) begin
            rdata_ff <= prioMain_ff;
         end else if ({araddr[ADDR_W-1:2], 2'h0} == OFF_PRIO_AUX) begin
            rdata_ff <= prioAux_ff;
         end else if ({araddr[ADDR_W-1:2], 2'h0} == OFF_CTRL) begin
            rdata_ff <= ctrl_ff;
         end else if ({araddr[ADDR_W-1:2], 2'h0} == OFF_TABLE) begin
            rdata_ff <= ctrl_ff[CB_VIEW] ?
               {16'h0, selCode[1], thirdCode[1], secCode[1], topCode[1]} :
               {16'h0, selCode[0], thirdCode[0], secCode[0], topCode[0]};
         end else if ({araddr[ADDR_W-1:2], 2'h0} == OFF_STATUS) begin
            rdata_ff <= {28'h0, freqWide_ff, status_ff};
         end else if ({araddr[ADDR_W-1:2], 2'h0} == OFF_VALID) begin
            rdata_ff <= {24'h0, clkValid};
         end else begin
            rresp_ff <= RESP_SLVERR;
         end
      end else if (rvalid_ff && rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   assign awready         = !awHeld_ff;
   assign wready          = !wHeld_ff;
   assign bvalid          = bvalid_ff;
   assign bresp           = bresp_ff;
   assign arready         = !rvalid_ff;
   assign rvalid          = rvalid_ff;
   assign rdata           = rdata_ff;
   assign rresp           = rresp_ff;
   assign mainSelCode     = selCode[0];
   assign auxSelCode      = selCode[1];
   assign bucketFillMax   = bucketFillMax_ff;
   assign enterPrelocked2 = enterPrelocked2_ff;
   assign selFailOut      = status_ff[SB_SELFAIL];
   assign freqLimitWide   = freqWide_ff;

   // plain automatic main loop: no external switch, automatic force code
   logic mainAuto;
   assign mainAuto = !extSwEn && (ctrl_ff[CF_MFORCE_LSB +: 4] == FORCE_AUTO_LO ||
                                  ctrl_ff[CF_MFORCE_LSB +: 4] == FORCE_AUTO_HI);

   property p_lostSel;
      @(posedge clk) disable iff (!nrst)
      mainAuto && !selInSet[0] |=> mainSelCode == $past(topNxt[0]);
   endproperty
   a_lostSel: assert property (p_lostSel) else $error("lost selection not replaced");

   property p_revertJump;
      @(posedge clk) disable iff (!nrst)
      mainAuto && revertEn && betterW[0] |=> mainSelCode == $past(topNxt[0]);
   endproperty
   a_revertJump: assert property (p_revertJump) else $error("revertive jump missed");

   property p_holdNonRev;
      @(posedge clk) disable iff (!nrst)
      mainAuto && !revertEn && selInSet[0] |=> $stable(mainSelCode);
   endproperty
   a_holdNonRev: assert property (p_holdNonRev) else $error("nonrevertive moved");

   property p_auxRevert;
      @(posedge clk) disable iff (!nrst)
      !phaseMode && ctrl_ff[CF_AFORCE_LSB +: 4] == FORCE_AUTO_LO && betterW[1]
      |=> auxSelCode == $past(topNxt[1]) && auxSelCode != $past(auxSelCode);
   endproperty
   a_auxRevert: assert property (p_auxRevert) else $error("aux not revertive");

   property p_extHigh;
      @(posedge clk) disable iff (!nrst)
      extSwEn && pinSync_ff |=> mainSelCode == INPUT_THREE || mainSelCode == INPUT_FIVE;
   endproperty
   a_extHigh: assert property (p_extHigh) else $error("pin high wrong input");

   property p_extLow;
      @(posedge clk) disable iff (!nrst)
      extSwEn && !pinSync_ff |=> mainSelCode == INPUT_FOUR || mainSelCode == INPUT_SIX;
   endproperty
   a_extLow: assert property (p_extLow) else $error("pin low wrong input");

   property p_badForce;
      @(posedge clk) disable iff (!nrst)
      !extSwEn && ctrl_ff[CF_MFORCE_LSB +: 4] == 4'h7 |=> mainSelCode == 4'h0;
   endproperty
   a_badForce: assert property (p_badForce) else $error("illegal force selected");

   property p_ufsPulse;
      @(posedge clk) disable iff (!nrst)
      ufsEn && fastMiss && mainSelCode != 4'h0
      |=> bucketFillMax && enterPrelocked2 && selFailOut ##1 !enterPrelocked2 || $past(fastMiss);
   endproperty
   a_ufsPulse: assert property (p_ufsPulse) else $error("ultra-fast switch missed");

   property p_betterFlag;
      @(posedge clk) disable iff (!nrst)
      $rose(betterW[0]) |=> status_ff[SB_BETTER_MAIN];
   endproperty
   a_betterFlag: assert property (p_betterFlag) else $error("better flag not set");

   c_ufs:    cover property (@(posedge clk) disable iff (!nrst) ufsTrig ##1 enterPrelocked2);
   c_revertive_enable: cover property (@(posedge clk) disable iff (!nrst) revertEn && betterW[0]);
   c_ext:    cover property (@(posedge clk) disable iff (!nrst) extSwEn && $changed(mainSelCode));
endmodule : dpll_reference_selector

// >>> src/dpll_sel_pkg.sv
package dpll_sel_pkg;
   localparam int          CODE_W          = 4;
   localparam int          NPOS            = 8;
   localparam int          KEY_W           = 7;
   localparam int          ADDR_W          = 8;
   localparam logic [7:0]  OFF_PRIO_MAIN   = 8'h00;
   localparam logic [7:0]  OFF_PRIO_AUX    = 8'h04;
   localparam logic [7:0]  OFF_CTRL        = 8'h08;
   localparam logic [7:0]  OFF_TABLE       = 8'h0C;
   localparam logic [7:0]  OFF_STATUS      = 8'h10;
   localparam logic [7:0]  OFF_VALID       = 8'h14;
   localparam int          CB_REVERTIVE_ENABLE       = 0;
   localparam int          CB_VIEW         = 1;
   localparam int          CB_UFS          = 2;
   localparam int          CB_EXTERNAL_SWITCH_ENABLE        = 3;
   localparam int          CB_PHASE        = 4;
   localparam int          CF_MFORCE_LSB   = 8;
   localparam int          CF_AFORCE_LSB   = 12;
   localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
   localparam int          SB_SELFAIL      = 0;
   localparam int          SB_BETTER_MAIN  = 1;
   localparam int          SB_BETTER_AUX   = 2;
   localparam int          SB_FREQ_WIDE    = 3;
   localparam int          TF_TOP_LSB      = 0;
   localparam int          TF_SECOND_LSB   = 4;
   localparam int          TF_THIRD_LSB    = 8;
   localparam int          TF_SEL_LSB      = 12;
   localparam logic [31:0] PRIO_MAIN_RST   = 32'h5400_3210;
   localparam logic [31:0] PRIO_AUX_RST    = 32'h0500_3210;
   localparam logic [3:0]  FORCE_AUTO_LO   = 4'h0;
   localparam logic [3:0]  FORCE_AUTO_HI   = 4'hF;
   localparam logic [3:0]  INPUT_THREE     = 4'h3;
   localparam logic [3:0]  INPUT_FOUR      = 4'h4;
   localparam logic [3:0]  INPUT_FIVE      = 4'h5;
   localparam logic [3:0]  INPUT_SIX       = 4'h6;
   localparam int          POS_THREE       = 2;
   localparam int          POS_FOUR        = 3;
   localparam int          FREQ_WIDE_PPM   = 80;
   localparam real         FREQ_NARROW_PPM = 9.2;
   localparam logic [1:0]  STRAP_WAIT      = 2'h2;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // positions 0..7 carry inputs 1..6, 8, 9
   function automatic logic [3:0] posToCode(input logic [2:0] p);
      posToCode = (p < 3'h6) ? {1'b0, p} + 4'h1 : {1'b0, p} + 4'h2;
   endfunction : posToCode

   // returns {legal, position}
   function automatic logic [3:0] codeToPos(input logic [3:0] c);
      if (c >= 4'h1 && c <= 4'h6) codeToPos = {1'b1, 3'(c - 4'h1)};
      else if (c == 4'h8 || c == 4'h9) codeToPos = {1'b1, 3'(c - 4'h2)};
      else codeToPos = 4'h0;
   endfunction : codeToPos
endpackage : dpll_sel_pkg

// >>> testbench/dpll_reference_selector_tb_top.sv
module dpll_reference_selector_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import dpll_sel_pkg::*;
   logic        clk = 1'b0, nrst = 1'b0, fastMiss = 1'b0, sourceSwitchPin = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0]  clkValid = 8'h00, awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd, wv;
   logic [3:0]  wstrb = 4'hF, mainSelCode, auxSelCode;
   logic [1:0]  bresp, rresp, rr, wb;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        bucketFillMax, enterPrelocked2, selFailOut, freqLimitWide;
   int          miscompares, tests_run, curM, curA, rv, pm[8], pa[8];
   int          cd[8] = '{1, 2, 3, 4, 5, 6, 8, 9};
   always #2.5 clk = ~clk;
   dpll_reference_selector dut_u (.clk(clk), .nrst(nrst), .clkValid(clkValid),
      .fastMiss(fastMiss), .sourceSwitchPin(sourceSwitchPin), .mainSelCode(mainSelCode),
      .auxSelCode(auxSelCode), .bucketFillMax(bucketFillMax), .enterPrelocked2(enterPrelocked2),
      .selFailOut(selFailOut), .freqLimitWide(freqLimitWide), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         miscompares++;
         $display("Error %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'b111;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      wb = bresp;
      bready <= 1'b0;
      // let an edge pass so the next call never reassigns bready in this step
      @(posedge clk);
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      araddr <= a;
      {arvalid, rready} <= 2'b11;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rr = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask : rdr
   // revertive pick: scan circularly from the current selection, so a tie never moves it
   function automatic int pick(input int p[8], input logic [7:0] v, input int c);
      int b = 16, r = -1, s = (c < 0) ? 0 : c;
      for (int i = 0; i < 8; i++) if (v[i] && p[i] != 0 && p[i] < b) b = p[i];
      // no selection: the circle starts at position 0
      for (int k = 0; k < 8; k++) if (r < 0 && v[(s + k) % 8] && p[(s + k) % 8] == b)
         r = (s + k) % 8;
      return r;
   endfunction : pick
   function automatic logic [3:0] ec(input int p);
      return (p < 0) ? 4'h0 : 4'(cd[p]);
   endfunction : ec
   // model steps once per change, as the design does
   task automatic upd(input int r);
      curM = (r == 0 && curM >= 0 && clkValid[curM] && pm[curM] != 0) ? curM
             : pick(pm, clkValid, curM);
      curA = pick(pa, clkValid, curA);
   endtask : upd
   task automatic settle(input logic [7:0] v);
      clkValid <= v;
      repeat (3) @(posedge clk);
      #1;
   endtask : settle
   task automatic end_sim;
      $display("tests_run %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   initial begin
      #60us;
      miscompares++;
      end_sim();
   end
   initial begin
      void'($urandom(64908));
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      rdr(OFF_PRIO_MAIN); chk("prioMain", PRIO_MAIN_RST, rd);
      rdr(OFF_PRIO_AUX); chk("prioAux", PRIO_AUX_RST, rd);
      rdr(OFF_CTRL); chk("ctrl", CTRL_RST, rd);
      chk("freqWide", 1'b0, freqLimitWide);
      rdr(8'h20);
      chk("unmappedResp", RESP_SLVERR, rr);
      chk("unmappedData", 32'h0, rd);
      wr(8'h20, 32'h0);
      chk("unmappedWr", RESP_SLVERR, wb);
      curM = -1;
      curA = -1;
      for (int n = 0; n < 40; n++) begin
         if (n % 8 == 0) begin
            for (int i = 0; i < 8; i++) begin
               pa[i] = $urandom % 4;
               wv[4*i+:4] = 4'(pa[i]);
            end
            wr(OFF_PRIO_AUX, wv);
            upd(rv);
            for (int i = 0; i < 8; i++) begin
               pm[i] = $urandom % 4;
               wv[4*i+:4] = 4'(pm[i]);
            end
            wr(OFF_PRIO_MAIN, wv);
            upd(rv);
         end
         rv = $urandom % 2;
         wr(OFF_CTRL, 32'(rv));
         upd(rv);
         settle(8'($urandom));
         upd(rv);
         chk("mainSel", ec(curM), mainSelCode);
         chk("auxSel", ec(curA), auxSelCode);
      end
      wr(OFF_STATUS, 32'hF);
      chk("wrOkay", RESP_OKAY, wb);
      wr(OFF_PRIO_MAIN, 32'h0000_0021);
      wr(OFF_CTRL, 32'h0);
      settle(8'h02);
      settle(8'h03);
      chk("nonrevSel", 4'h2, mainSelCode);
      rdr(OFF_TABLE); chk("top", 4'h1, rd[3:0]);
      rdr(OFF_STATUS); chk("better", 1'b1, rd[SB_BETTER_MAIN]);
      wr(OFF_CTRL, 32'h1);
      wr(OFF_CTRL, 32'h0);
      settle(8'h03);
      chk("pulseSel", 4'h1, mainSelCode);
      wr(OFF_PRIO_MAIN, 32'h8765_4321);
      for (int f = 0; f < 16; f++) begin
         wr(OFF_CTRL, 32'h1 | (f << CF_MFORCE_LSB));
         settle(8'hFF);
         chk("force", (f == 0 || f == 15) ? 4'h1 : (f == 7 || f > 9) ? 4'h0 : 4'(f),
             mainSelCode);
         rdr(OFF_TABLE);
         if (f > 2 && f < 7) chk("forceTab", 12'h210 | f, rd[11:0]);
      end
      wr(OFF_CTRL, 32'h1);
      settle(8'hFF);
      wr(OFF_CTRL, 32'h4);
      fastMiss <= 1'b1;
      @(posedge clk);
      fastMiss <= 1'b0;
      #1;
      chk("ufs", 3'b111, {bucketFillMax, enterPrelocked2, selFailOut});
      @(posedge clk);
      #1;
      chk("ufsSel", 4'h2, mainSelCode);
      for (int k = 0; k < 4; k++) begin
         wr(OFF_PRIO_MAIN, (k < 2) ? 32'h8765_4321 : 32'h8760_0021);
         wr(OFF_CTRL, 32'h9);
         sourceSwitchPin <= k[0];
         settle(8'h00);
         repeat (3) @(posedge clk);
         chk("extSel", 4'(3 + (k[0] ? 0 : 1) + (k < 2 ? 0 : 2)), mainSelCode);
         rdr(OFF_TABLE); chk("extTab", 12'h0, rd[11:0]);
      end
      // phase measure with aux force 6, table view on the aux loop
      wr(OFF_CTRL, 32'h12 | (32'h6 << CF_AFORCE_LSB));
      settle(8'h00);
      chk("phaseSel", 4'h6, auxSelCode);
      rdr(OFF_TABLE);
      chk("auxView", 16'h6000, rd[15:0]);
      end_sim();
   end
endmodule : dpll_reference_selector_tb_top
